// ==== design/usdp_data_port.sv ====
// Purpose: uart data port with receive and transmit queues behind AXI4-Lite
// Assumes: 8N1 framing at a fixed divider, infrared lines as bit-level pulses
// Notes: every alias of the sixteen-word window reaches the same data port
`timescale 1ns/1ps
`default_nettype none
// Contract
// - The data port answers at each of sixteen consecutive word aliases for bursts.
// - A read returns the received byte in bits 7 to 0, from the serial or infrared input.
// - Read data is valid only while rx_data_ready is set, which software checks first.
// - With queues off, an unread byte is overwritten by the next and overrun is flagged.
// - With queues on, a read returns the head of the receive queue.
// - A character arriving into a full receive queue is dropped and overrun is flagged.
// - A written byte is sent on the serial output, or the active-low infrared output.
// - With queues off, one write into an empty holding slot clears tx_holding_empty.
// - With queues off, further writes before the slot empties replace the held byte.
// - With queues on, up to the queue depth of characters are taken before full.
// - A write while the transmit queue is full is dropped without change.
module usdp_data_port (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ser_in,
  input wire logic ir_in,
  output logic ser_out,
  output logic ir_out_n,
  output logic irq
);
  import usdp_pkg::*;

  usdp_fifo_if rxq();
  usdp_fifo_if txq();

  usdp_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .f(rxq)
  );
  usdp_fifo #(.DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .f(txq)
  );

  function automatic logic is_alias(input logic [31:0] a);
    is_alias = (a[1:0] == 2'b00) && (a >= ALIAS_BASE) &&
               (a < ALIAS_BASE + 32'(ALIAS_COUNT * 4));
  endfunction

  // ---------------- control and status registers
  logic [1:0] ctrl_reg;
  logic [IRQ_BITS-1:0] imask_reg;
  logic [IRQ_BITS-1:0] istat_reg;
  logic overrun_reg;
  logic tx_holding_empty_prev_reg;
  logic tx_busy;
  logic rx_done;
  logic [7:0] rx_byte_reg;
  logic wr_do;
  logic rd_do;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [IRQ_BITS-1:0] ev;
  logic rx_overrun_ev;
  logic ctrl_wr;

  // ---------------- AXI write channel
  assign wr_do = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign ctrl_wr = wr_do && (awaddr_reg == CTRL_ADDR) && wstrb_reg[0];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_hold_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_hold_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (is_alias(awaddr_reg) || awaddr_reg == CTRL_ADDR ||
                        awaddr_reg == LSTAT_ADDR || awaddr_reg == ISTAT_ADDR ||
                        awaddr_reg == IMASK_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
      imask_reg <= IMASK_RESET;
    end else if (wr_do && wstrb_reg[0]) begin
      if (awaddr_reg == CTRL_ADDR) begin
        ctrl_reg <= wdata_reg[1:0];
      end
      if (awaddr_reg == IMASK_ADDR) begin
        imask_reg <= wdata_reg[IRQ_BITS-1:0];
      end
    end
  end

  // changing the queue mode empties both queues so no stale byte leaks across
  assign rxq.flush = ctrl_wr && (wdata_reg[CTRL_FIFO_EN] != ctrl_reg[CTRL_FIFO_EN]);
  assign txq.flush = rxq.flush;
  assign rxq.single = !ctrl_reg[CTRL_FIFO_EN];
  assign txq.single = !ctrl_reg[CTRL_FIFO_EN];

  // only byte lane 0 carries data, bits 31:8 are dropped
  assign txq.push = wr_do && is_alias(awaddr_reg) && wstrb_reg[0];
  assign txq.wdata = wdata_reg[7:0];
  // single slot replaces the held byte, a full queue drops the write
  assign txq.ovw = !ctrl_reg[CTRL_FIFO_EN];

  // ---------------- AXI read channel
  assign rd_do = s_axi_arvalid && s_axi_arready;
  assign rxq.pop = rd_do && is_alias(s_axi_araddr);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (rd_do) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if (is_alias(s_axi_araddr)) begin
          // head byte, stale when rx_data_ready is clear
          s_axi_rdata <= {24'h00_0000, rxq.rdata};
        end else if (s_axi_araddr == CTRL_ADDR) begin
          s_axi_rdata <= {30'h0000_0000, ctrl_reg};
        end else if (s_axi_araddr == LSTAT_ADDR) begin
          s_axi_rdata <= {25'h000_0000, !tx_busy && txq.empty, txq.empty,
                          3'h0, overrun_reg, !rxq.empty};
        end else if (s_axi_araddr == ISTAT_ADDR) begin
          s_axi_rdata <= {29'h0000_0000, istat_reg};
        end else if (s_axi_araddr == IMASK_ADDR) begin
          s_axi_rdata <= {29'h0000_0000, imask_reg};
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------- overrun and interrupts, set wins over read-clear
  assign rx_overrun_ev = rx_done && rxq.full && !rxq.pop;
  assign ev = {txq.empty && !tx_holding_empty_prev_reg, rx_overrun_ev, rx_done};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      overrun_reg <= 1'b0;
      istat_reg <= '0;
      tx_holding_empty_prev_reg <= 1'b1;
      irq <= 1'b0;
    end else begin
      tx_holding_empty_prev_reg <= txq.empty;
      if (rx_overrun_ev) begin
        overrun_reg <= 1'b1;
      end else if (rd_do && s_axi_araddr == LSTAT_ADDR) begin
        overrun_reg <= 1'b0;
      end
      if (rd_do && s_axi_araddr == ISTAT_ADDR) begin
        istat_reg <= ev;
      end else begin
        istat_reg <= istat_reg | ev;
      end
      irq <= |((istat_reg | ev) & imask_reg);
    end
  end

  // ---------------- receiver
  logic ser_s1_reg;
  logic ser_s2_reg;
  logic ir_s1_reg;
  logic ir_s2_reg;
  logic rx_line;
  usdp_line_e rx_state_reg;
  logic [15:0] rx_cnt_reg;
  logic [2:0] rx_bit_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ser_s1_reg <= 1'b1;
      ser_s2_reg <= 1'b1;
      ir_s1_reg <= 1'b0;
      ir_s2_reg <= 1'b0;
    end else begin
      ser_s1_reg <= ser_in;
      ser_s2_reg <= ser_s1_reg;
      ir_s1_reg <= ir_in;
      ir_s2_reg <= ir_s1_reg;
    end
  end

  // infrared input pulses high for each zero bit
  assign rx_line = ctrl_reg[CTRL_IR_MODE] ? !ir_s2_reg : ser_s2_reg;
  assign rx_done = (rx_state_reg == USDP_STOP) && (rx_cnt_reg == '0) && rx_line;
  assign rxq.push = rx_done;
  assign rxq.wdata = rx_byte_reg;
  // a disabled queue keeps only the newest byte, an enabled one keeps the oldest
  assign rxq.ovw = !ctrl_reg[CTRL_FIFO_EN];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_state_reg <= USDP_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_byte_reg <= '0;
    end else begin
      if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end
      case (rx_state_reg)
        USDP_IDLE: begin
          if (!rx_line) begin
            rx_state_reg <= USDP_START;
            rx_cnt_reg <= BAUD_HALF;
          end
        end
        USDP_START: begin
          if (rx_cnt_reg == '0) begin
            // a start bit gone by mid-bit was a glitch
            rx_state_reg <= rx_line ? USDP_IDLE : USDP_DATA;
            rx_cnt_reg <= BAUD_DIV;
            rx_bit_reg <= '0;
          end
        end
        USDP_DATA: begin
          if (rx_cnt_reg == '0) begin
            rx_byte_reg <= {rx_line, rx_byte_reg[7:1]};
            rx_cnt_reg <= BAUD_DIV;
            rx_bit_reg <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= USDP_STOP;
            end
          end
        end
        USDP_STOP: begin
          // framing errors are dropped silently
          if (rx_cnt_reg == '0) begin
            rx_state_reg <= USDP_IDLE;
          end
        end
        default: begin
          rx_state_reg <= USDP_IDLE;
        end
      endcase
    end
  end

  // ---------------- transmitter
  usdp_line_e tx_state_reg;
  logic [15:0] tx_cnt_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_line;

  assign tx_busy = (tx_state_reg != USDP_IDLE);
  assign txq.pop = !tx_busy && !txq.empty;
  assign tx_line = (tx_state_reg == USDP_START) ? 1'b0 :
                   (tx_state_reg == USDP_DATA) ? tx_shift_reg[0] : 1'b1;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_state_reg <= USDP_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= '0;
    end else begin
      if (tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - 1'b1;
      end
      case (tx_state_reg)
        USDP_IDLE: begin
          if (txq.pop) begin
            tx_shift_reg <= txq.rdata;
            tx_cnt_reg <= BAUD_DIV;
            tx_state_reg <= USDP_START;
          end
        end
        USDP_START: begin
          if (tx_cnt_reg == '0) begin
            tx_cnt_reg <= BAUD_DIV;
            tx_bit_reg <= '0;
            tx_state_reg <= USDP_DATA;
          end
        end
        USDP_DATA: begin
          if (tx_cnt_reg == '0) begin
            tx_cnt_reg <= BAUD_DIV;
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 1'b1;
            if (tx_bit_reg == 3'h7) begin
              tx_state_reg <= USDP_STOP;
            end
          end
        end
        USDP_STOP: begin
          if (tx_cnt_reg == '0) begin
            tx_state_reg <= USDP_IDLE;
          end
        end
        default: begin
          tx_state_reg <= USDP_IDLE;
        end
      endcase
    end
  end

  // the unused line idles: serial high, infrared not pulsing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ser_out <= 1'b1;
      ir_out_n <= 1'b1;
    end else begin
      ser_out <= ctrl_reg[CTRL_IR_MODE] ? 1'b1 : tx_line;
      ir_out_n <= ctrl_reg[CTRL_IR_MODE] ? tx_line : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== design/usdp_pkg.sv ====
// Purpose: constants shared by the shadow data port design
// Assumes: 32-bit AXI4-Lite register access, 40 MHz clk_sys
// Notes: line format is fixed at 8 data bits, no parity, one stop bit
package usdp_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD_HZ);
  localparam logic [15:0] BAUD_HALF = 16'(CLK_HZ / BAUD_HZ / 2);
  localparam int FIFO_DEPTH = 16;

  // sixteen word aliases of the data port, ours is the ninth
  localparam logic [31:0] ALIAS_BASE = 32'h5000_1130;
  localparam int ALIAS_COUNT = 16;
  localparam logic [31:0] DATA_ALIAS_ADDR = 32'h5000_1150;
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1200;
  localparam logic [31:0] LSTAT_ADDR = 32'h5000_1204;
  localparam logic [31:0] ISTAT_ADDR = 32'h5000_1208;
  localparam logic [31:0] IMASK_ADDR = 32'h5000_120C;

  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_IR_MODE = 1;
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_TX_IDLE = 6;
  localparam int IRQ_RX = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_TX_EMPTY = 2;
  localparam int IRQ_BITS = 3;

  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [2:0] IMASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    USDP_IDLE = 2'b00,
    USDP_START = 2'b01,
    USDP_DATA = 2'b11,
    USDP_STOP = 2'b10
  } usdp_line_e;
endpackage

// ==== design/usdp_fifo_if.sv ====
// Purpose: carrier between the data port and its character queues
// Assumes: one owner drives the requests, one queue answers
// Notes: full and empty are combinational answers of the queue
`timescale 1ns/1ps
`default_nettype none
interface usdp_fifo_if;
  logic push;
  logic pop;
  logic ovw;
  logic flush;
  logic single;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic full;
  logic empty;
  modport owner(output push, pop, ovw, flush, single, wdata, input rdata, full, empty);
  modport store(input push, pop, ovw, flush, single, wdata, output rdata, full, empty);
endinterface
`default_nettype wire

// ==== design/usdp_fifo.sv ====
// Purpose: character queue, full depth or a single holding slot
// Assumes: push and pop are one-cycle requests on clk_sys
// Notes: a push into a full queue is dropped unless a pop in the same cycle frees room or ovw asks to replace
`timescale 1ns/1ps
`default_nettype none
module usdp_fifo #(
  parameter int DEPTH = usdp_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  usdp_fifo_if.store f
);
  import usdp_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CAP = (AW + 1)'(DEPTH);

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] wr_ptr_reg;
  logic [AW:0] count_reg;
  logic full_now;
  logic push_ok;
  logic pop_ok;
  logic replace;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign full_now = f.single ? (count_reg != '0) : (count_reg == CAP);
  assign pop_ok = f.pop && (count_reg != '0);
  assign push_ok = f.push && (!full_now || pop_ok);
  assign replace = f.push && full_now && !pop_ok && f.ovw;
  assign f.full = full_now;
  assign f.empty = (count_reg == '0);
  assign f.rdata = mem[rd_ptr_reg];

  always_ff @(posedge clk_sys) begin
    if (push_ok) begin
      mem[wr_ptr_reg] <= f.wdata;
    end else if (replace) begin
      mem[rd_ptr_reg] <= f.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg <= '0;
    end else if (f.flush) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop_ok) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      count_reg <= count_reg + (AW + 1)'(push_ok) - (AW + 1)'(pop_ok);
    end
  end
endmodule
`default_nettype wire

// ==== tb/usdp_asserts.sv ====
// Purpose: port checks for the shadow data port
// Assumes: one clk_sys domain, rstn asynchronous and active low
// Notes: watches top-level ports only, bound below the module
`timescale 1ns/1ps
`default_nettype none
module usdp_asserts (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ser_out,
  input wire logic ir_out_n,
  input wire logic irq
);
  import usdp_pkg::*;
  logic [11:0] low_run;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // low runs hold whole bit times; a counter avoids a long repetition
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) low_run <= 12'h000;
    else if (ser_out) low_run <= 12'h000;
    else low_run <= low_run + 12'h001;
  end
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in the next cycle");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped before taken");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted while one is open");
  // the held request is applied one cycle before the response rises
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  chk_lines_apart: assert property (ser_out || ir_out_n)
    else $error("serial and infrared outputs active together");
  // a bit lasts the reload count plus the cycle spent at zero
  chk_bit_time: assert property ($rose(ser_out) |->
    16'(low_run) % (BAUD_DIV + 16'h0001) == 16'h0000)
    else $error("serial low run not a whole number of bits");
  chk_reset_quiet: assert property ($rose(rstn) |->
    s_axi_awready && s_axi_arready && !s_axi_bvalid && !irq) else $error("bad state after reset");
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[7:0] != 8'h00);
  cover property ($fell(ir_out_n));
  cover property ($rose(irq));
endmodule
bind usdp_data_port usdp_asserts u_chk (.clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ser_out, .ir_out_n, .irq);
`default_nettype wire

// ==== tb/usdp_line_model.sv ====
// Purpose: far-side transceiver on the serial and infrared pins
// Assumes: 8N1 frames, lsb first, BAUD_DIV clocks a bit
// Notes: infrared lines are the inverted bit level, no pulse shaping
`timescale 1ns/1ps
`default_nettype none
module usdp_line_model (
  input wire logic clk_sys,
  input wire logic ir_mode,
  input wire logic ser_out,
  input wire logic ir_out_n,
  output logic ser_in,
  output logic ir_in
);
  import usdp_pkg::*;
  logic line;
  logic mon;
  logic [7:0] got;
  event got_ev;
  assign ser_in = ir_mode ? 1'b1 : line;
  assign ir_in = ir_mode ? ~line : 1'b0;
  assign mon = ir_mode ? ir_out_n : ser_out;
  // idle gap lets the caller vary between prompt and slow senders
  task automatic send_byte(input logic [7:0] b, input int gap);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    repeat (gap) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      line <= fr[i];
      repeat (BAUD_DIV) @(posedge clk_sys);
    end
  endtask
  initial begin
    line = 1'b1;
    forever begin
      @(negedge mon);
      repeat (BAUD_DIV / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge clk_sys);
        got[i] = mon;
      end
      repeat (BAUD_DIV) @(posedge clk_sys);
      -> got_ev;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_uart_shadow_data_port.sv ====
// Purpose: self-checking bench for the shadow data port
// Assumes: 40 MHz clk_sys, far-side transceiver model on the line pins
// Notes: expected results are queued and a monitor compares them in order
`timescale 1ns/1ps
`default_nettype none
module tb_uart_shadow_data_port;
  import usdp_pkg::*;
  logic clk_sys, rstn, ir_sel, ser_in, ir_in, ser_out, ir_out_n, irq;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] rb [17];
  logic [33:0] rd_q [$];
  logic [1:0] b_q [$];
  logic [7:0] tx_q [$];
  int miscompares = 0;
  int checks = 0;
  usdp_data_port dut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ser_in,
    .ir_in, .ser_out, .ir_out_n, .irq);
  usdp_line_model far (.clk_sys, .ir_mode(ir_sel), .ser_out, .ir_out_n, .ser_in, .ir_in);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    miscompares++;
    $display("CHECK FAILED %s expected answer seen none", nm);
    give_verdict();
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge clk_sys);
    b_q.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awprot <= 3'($urandom);
    s_axi_wstrb <= {3'($urandom), 1'b1};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 99) hang("write");
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int n;
    @(posedge clk_sys);
    rd_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arprot <= 3'($urandom);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 99) hang("read");
  endtask
  // waits for every queued byte to leave, then for the last stop bit
  task automatic drain();
    int n;
    for (n = 0; n < 90000 && tx_q.size() != 0; n++) @(posedge clk_sys);
    if (n == 90000) hang("line byte");
    repeat (400) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) chk("read", rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(b_q.pop_front()), 34'(s_axi_bresp));
  end
  always @(far.got_ev) chk("line byte", 34'(tx_q.pop_front()), 34'(far.got));
  initial begin
    logic [7:0] a;
    logic [7:0] c;
    {rstn, ir_sel, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
    void'($urandom(32'h0000_64f4));
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(LSTAT_ADDR, 34'h0_0000_0060);
    rd(32'h5000_1300, {RESP_SLVERR, 32'h0000_0000});
    wr(32'h5000_1300, 32'h0000_00ff, RESP_SLVERR);
    a = 8'($urandom);
    c = 8'($urandom);
    tx_q = '{a, c};
    wr(DATA_ALIAS_ADDR, {24'($urandom), a}, RESP_OKAY);
    wr(DATA_ALIAS_ADDR, {24'($urandom), ~c}, RESP_OKAY);
    rd(LSTAT_ADDR, 34'h0_0000_0000);
    wr(DATA_ALIAS_ADDR, {24'($urandom), c}, RESP_OKAY);
    rb[0] = 8'($urandom);
    rb[1] = ~rb[0];
    far.send_byte(rb[0], 0);
    far.send_byte(rb[1], 9);
    drain();
    rd(LSTAT_ADDR, 34'h0_0000_0063);
    chk("irq", 34'h0_0000_0000, 34'(irq));
    wr(IMASK_ADDR, 32'h0000_0007, RESP_OKAY);
    #60 chk("irq", 34'h0_0000_0001, 34'(irq));
    rd(IMASK_ADDR, 34'h0_0000_0007);
    rd(ISTAT_ADDR, 34'h0_0000_0007);
    #60 chk("irq", 34'h0_0000_0000, 34'(irq));
    rd(DATA_ALIAS_ADDR, {26'h000_0000, rb[1]});
    rd(LSTAT_ADDR, 34'h0_0000_0060);
    wr(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
    rd(CTRL_ADDR, 34'h0_0000_0001);
    for (int i = 0; i < 18; i++) begin
      a = 8'($urandom);
      if (i < 17) tx_q.push_back(a);
      wr(ALIAS_BASE + 32'(4 * (i % 16)), {24'($urandom), a}, RESP_OKAY);
    end
    rd(LSTAT_ADDR, 34'h0_0000_0000);
    for (int i = 0; i < 17; i++) begin
      rb[i] = 8'($urandom);
      far.send_byte(rb[i], $urandom_range(40));
    end
    drain();
    rd(LSTAT_ADDR, 34'h0_0000_0063);
    for (int i = 0; i < 16; i++) rd(ALIAS_BASE + 32'(4 * i), {26'h000_0000, rb[i]});
    rd(LSTAT_ADDR, 34'h0_0000_0060);
    wr(CTRL_ADDR, 32'h0000_0002, RESP_OKAY);
    ir_sel <= 1'b1;
    a = 8'($urandom);
    tx_q.push_back(a);
    wr(DATA_ALIAS_ADDR, {24'($urandom), a}, RESP_OKAY);
    rb[0] = 8'($urandom);
    far.send_byte(rb[0], 5);
    drain();
    rd(LSTAT_ADDR, 34'h0_0000_0061);
    rd(DATA_ALIAS_ADDR, {26'h000_0000, rb[0]});
    give_verdict();
  end
endmodule
`default_nettype wire
